// [rtl/pulse_mod_ctrl.v]
// What this block does
// - With the marker set to synchronization, one pulse marks the setting of the modulation enable; off after reset.
// - With synchronization off, the marker is 1 while the RF output settles and 0 once it is stable.
// - Video polarity normal blanks RF in the pulse pause, inverted blanks it during the pulse; normal after reset.
// - Modulation polarity inversion, normal after reset, acts only on the external modulating signal.
// - The internal generator repeats at a programmable period of 50 ns to 100 s in 5 ns steps, 10 us after reset.
// - In the reduced variant the period has a 5 us minimum and 1 us granularity.
// - The source select routes the external input, the internal generator or random noise pulses to the modulator.
// - Modulation with the selected source is applied only while the enable is set; the enable is clear after reset.
// - With resynchronization on, the external signal is retimed to the reference clock before the modulator.
// - With resynchronization off, the external signal reaches the modulator without being sampled on any clock.
`timescale 1ns/1ps
`include "pmc_consts.vh"
module pulse_mod_ctrl
#(
    parameter ENHANCED = 1,
    parameter ADDR_W = 8
)
(
    input wire i_clk,
    input wire i_sys_rst,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire i_pulse_in,
    output wire o_pulse_mod,
    output wire o_rf_blank,
    output reg o_marker
);
    localparam PW = `PMC_PER_W;
    localparam [63:0] STEPS_RST = `PMC_PER_RST_NS / `PMC_STEP_NS;
    localparam [63:0] STEPS_MIN_ENH = `PMC_PER_MIN_ENH_NS / `PMC_STEP_NS;
    localparam [63:0] STEPS_MAX = (64'd1000000000 * `PMC_PER_MAX_S) / `PMC_STEP_NS;
    localparam [63:0] STEPS_MIN_RED = `PMC_PER_MIN_RED_NS / `PMC_STEP_NS;
    localparam [63:0] STEPS_GRAN_RED = `PMC_PER_GRAN_RED_NS / `PMC_STEP_NS;
    localparam [63:0] STEPS_PER_CLK = `PMC_CLK_NS / `PMC_STEP_NS;
    localparam [63:0] SETTLE_CYC_L = (`PMC_SETTLE_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS;
    localparam [PW-1:0] PER_RST = STEPS_RST[PW-1:0];
    localparam [PW-1:0] PER_MAX = STEPS_MAX[PW-1:0];
    localparam [PW-1:0] PER_GRAN = STEPS_GRAN_RED[PW-1:0];
    localparam [PW-1:0] INC = STEPS_PER_CLK[PW-1:0];
    localparam [PW-1:0] PER_MIN_RAW = ENHANCED ? STEPS_MIN_ENH[PW-1:0] : STEPS_MIN_RED[PW-1:0];
    // the accumulator can only wrap once per clock
    localparam [PW-1:0] PER_MIN = (PER_MIN_RAW > INC) ? PER_MIN_RAW : INC;
    localparam [7:0] SETTLE_CYC = SETTLE_CYC_L[7:0];

    reg [`PMC_CTRL_W-1:0] ctrl;
    reg [PW-1:0] period;
    reg aw_held;
    reg w_held;
    reg [ADDR_W-1:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [PW-1:0] acc;
    reg gen_out;
    reg [7:0] settle_cnt;
    reg en_q;
    reg [PW-1:0] eff_period;
    reg [PW-1:0] next_acc;
    reg [31:0] wmask;
    reg [31:0] rd_word;
    reg rd_ok;
    reg int_mod;

    wire ext_sync;
    wire noise_bit;
    wire mod_en = ctrl[`PMC_CTRL_EN];
    wire [1:0] sel = ctrl[`PMC_CTRL_SEL_LSB+1:`PMC_CTRL_SEL_LSB];
    wire ext_path;
    wire mod_sig;
    wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
    wire [31:0] per_lo_new;
    wire [31:0] per_hi_new;
    wire [31:0] per_hi_word = {{(64-PW){1'b0}}, period[PW-1:32]};

    resync_two_stage u_resync
    (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async(i_pulse_in),
        .o_sync(ext_sync)
    );

    noise_lfsr #(.WIDTH(23), .SEED(23'h000001), .TAPS(23'h420000)) u_noise
    (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .o_bit(noise_bit)
    );

    // byte lane mask from write strobes
    always @*
    begin
        wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    end

    assign per_lo_new = (period[31:0] & ~wmask) | (w_data & wmask);
    assign per_hi_new = (per_hi_word & ~wmask) | (w_data & wmask);

    // write channel: address and data taken in any order
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= {ADDR_W{1'b0}};
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PMC_RESP_OKAY;
            ctrl <= `PMC_CTRL_RST;
            period <= PER_RST;
        end
        else
        begin
            s_axi_awready <= ~aw_held & ~s_axi_bvalid & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready <= ~w_held & ~s_axi_bvalid & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid & s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `PMC_RESP_OKAY;
                if (aw_addr == `PMC_CTRL_OFS)
                begin
                    ctrl <= (ctrl & ~wmask[`PMC_CTRL_W-1:0]) | (w_data[`PMC_CTRL_W-1:0] & wmask[`PMC_CTRL_W-1:0]);
                end
                else if (aw_addr == `PMC_PER_LO_OFS)
                begin
                    period[31:0] <= per_lo_new;
                end
                else if (aw_addr == `PMC_PER_HI_OFS)
                begin
                    period[PW-1:32] <= per_hi_new[PW-33:0];
                end
                else if (aw_addr == `PMC_STAT_OFS)
                begin
                    s_axi_bresp <= `PMC_RESP_OKAY;
                end
                else
                begin
                    s_axi_bresp <= `PMC_RESP_SLVERR;
                end
            end
        end
    end

    // read decode
    always @*
    begin
        rd_word = 32'h00000000;
        rd_ok = 1'b1;
        if (s_axi_araddr == `PMC_CTRL_OFS)
        begin
            rd_word[`PMC_CTRL_W-1:0] = ctrl;
        end
        else if (s_axi_araddr == `PMC_PER_LO_OFS)
        begin
            rd_word = period[31:0];
        end
        else if (s_axi_araddr == `PMC_PER_HI_OFS)
        begin
            rd_word = per_hi_word;
        end
        else if (s_axi_araddr == `PMC_STAT_OFS)
        begin
            rd_word[`PMC_STAT_SETTLE] = (settle_cnt != 8'h00);
            rd_word[`PMC_STAT_GEN] = gen_out;
            rd_word[`PMC_STAT_MOD] = mod_sig;
            rd_word[`PMC_STAT_EXT] = ext_sync;
        end
        else
        begin
            rd_ok = 1'b0;
        end
    end

    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PMC_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid & s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
            end
            else if (s_axi_rvalid & s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // effective period in 5 ns steps
    always @*
    begin
        eff_period = period;
        if (ENHANCED == 0)
        begin
            eff_period = (period / PER_GRAN) * PER_GRAN;
        end
        if (eff_period < PER_MIN)
        begin
            eff_period = PER_MIN;
        end
        else if (eff_period > PER_MAX)
        begin
            eff_period = PER_MAX;
        end
    end

    // phase accumulator advancing one clock of steps per cycle
    always @*
    begin
        next_acc = acc + INC;
        if (next_acc >= eff_period)
        begin
            next_acc = next_acc - eff_period;
        end
    end

    // internal generator, high for the first half period
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            acc <= {PW{1'b0}};
            gen_out <= 1'b0;
        end
        else if (!mod_en)
        begin
            acc <= {PW{1'b0}};
            gen_out <= 1'b0;
        end
        else
        begin
            acc <= next_acc;
            gen_out <= (next_acc < (eff_period >> 1));
        end
    end

    // source routing for the clocked sources
    always @*
    begin
        case (sel)
            `PMC_SEL_INT: int_mod = gen_out;
            `PMC_SEL_RAND: int_mod = noise_bit;
            `PMC_SEL_EXT: int_mod = ext_sync ^ ctrl[`PMC_CTRL_INV];
            default: int_mod = 1'b0;
        endcase
    end

    // unsampled external path when resync is off
    assign ext_path = (sel == `PMC_SEL_EXT) & ~ctrl[`PMC_CTRL_RESYNC];
    assign mod_sig = ext_path ? (i_pulse_in ^ ctrl[`PMC_CTRL_INV]) : int_mod;
    assign o_pulse_mod = mod_en & mod_sig;
    // blank in pause or in pulse
    assign o_rf_blank = mod_en & (mod_sig ^ ~ctrl[`PMC_CTRL_BLANK]);

    // settling timer restarted by any configuration write
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            settle_cnt <= SETTLE_CYC;
            en_q <= 1'b0;
            o_marker <= 1'b1;
        end
        else
        begin
            en_q <= mod_en;
            if (wr_fire && (aw_addr != `PMC_STAT_OFS))
            begin
                settle_cnt <= SETTLE_CYC;
            end
            else if (settle_cnt != 8'h00)
            begin
                settle_cnt <= settle_cnt - 8'h01;
            end
            if (ctrl[`PMC_CTRL_MARK])
            begin
                o_marker <= mod_en & ~en_q;
            end
            else
            begin
                o_marker <= (settle_cnt != 8'h00);
            end
        end
    end
endmodule // pulse_mod_ctrl

// [rtl/pmc_consts.vh]
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH

// register byte offsets
`define PMC_CTRL_OFS 8'h00
`define PMC_PER_LO_OFS 8'h04
`define PMC_PER_HI_OFS 8'h08
`define PMC_STAT_OFS 8'h0c

// control register fields
`define PMC_CTRL_EN 0
`define PMC_CTRL_MARK 1
`define PMC_CTRL_BLANK 2
`define PMC_CTRL_INV 3
`define PMC_CTRL_RESYNC 4
`define PMC_CTRL_SEL_LSB 5
`define PMC_CTRL_W 7
`define PMC_CTRL_RST 7'h00

// input_select codes
`define PMC_SEL_EXT 2'h0
`define PMC_SEL_INT 2'h1
`define PMC_SEL_RAND 2'h2

// status register fields
`define PMC_STAT_SETTLE 0
`define PMC_STAT_GEN 1
`define PMC_STAT_MOD 2
`define PMC_STAT_EXT 3

// axi response codes
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2

// timing, in ns unless named otherwise
`define PMC_CLK_NS 50
`define PMC_STEP_NS 5
`define PMC_PER_RST_NS 10000
`define PMC_PER_MIN_ENH_NS 20
`define PMC_PER_MAX_S 100
`define PMC_PER_MIN_RED_NS 5000
`define PMC_PER_GRAN_RED_NS 1000
`define PMC_SETTLE_NS 2000
`define PMC_PER_W 36

`endif

// [rtl/resync_two_stage.v]
`timescale 1ns/1ps
module resync_two_stage
(
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_async,
    output reg o_sync
);
    reg stage_one;

    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            stage_one <= 1'b0;
            o_sync <= 1'b0;
        end
        else
        begin
            stage_one <= i_async;
            o_sync <= stage_one;
        end
    end
endmodule // resync_two_stage

// [rtl/noise_lfsr.v]
`timescale 1ns/1ps
module noise_lfsr
#(
    parameter WIDTH = 23,
    parameter [WIDTH-1:0] SEED = 23'h000001,
    parameter [WIDTH-1:0] TAPS = 23'h420000
)
(
    input wire i_clk,
    input wire i_sys_rst,
    output reg o_bit
);
    reg [WIDTH-1:0] state;

    // galois shift, never reaches all zero
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            state <= SEED;
            o_bit <= 1'b0;
        end
        else
        begin
            state <= state[0] ? ((state >> 1) ^ TAPS) : (state >> 1);
            o_bit <= state[0];
        end
    end
endmodule // noise_lfsr

// [bench/pmc_assertions.sv]
`timescale 1ns/1ps
module pmc_assertions
(
    input wire i_clk,
    input wire i_sys_rst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire o_pulse_mod,
    input wire o_rf_blank,
    input wire o_marker
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response missing two cycles after address and data");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing one cycle after address");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while read data pending");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_read_return: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
        else $error("read channel did not return to ready");
    a_write_return: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready))
        else $error("write channel did not return to ready");
    a_ready_release: assert property ($fell(i_sys_rst) |=> s_axi_awready && s_axi_wready && s_axi_arready)
        else $error("ready signals not raised after reset release");
    a_marker_settle: assert property ($fell(i_sys_rst) |-> o_marker [*8])
        else $error("marker not showing settling after reset");
    a_output_idle: assert property ($fell(i_sys_rst) |-> !o_pulse_mod && !o_rf_blank)
        else $error("modulation outputs active after reset");
endmodule // pmc_assertions

// [bench/pulse_source.sv]
`timescale 1ns/1ps
module pulse_source
#(
    parameter HIGH_NS = 137,
    parameter LOW_NS = 211
)
(
    input wire i_run,
    output reg o_pulse
);
    initial o_pulse = 1'b0;
    // free-running pulse train, phase unrelated to the bench clock; idles low
    always
    begin
        wait (i_run);
        #(LOW_NS) o_pulse = 1'b1;
        #(HIGH_NS) o_pulse = 1'b0;
    end
endmodule // pulse_source

// [bench/test_pulse_modulation_control.sv]
`timescale 1ns/1ps
`include "pmc_consts.vh"
module test_pulse_modulation_control;
    reg i_clk = 1'b0, i_sys_rst = 1'b1, tb_level = 1'b0, use_src = 1'b0, prev, prev_red;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0;
    wire [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    wire [3:0] s_axi_wstrb = 4'hf;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire src_pulse, o_pulse_mod, o_rf_blank, o_marker, red_pulse_mod;
    wire i_pulse_in = use_src ? src_pulse : tb_level;
    integer fail_count = 0, num_checks = 0, cycles = 0, mark_cnt = 0, hi, rises, red_rises, k;

    pulse_mod_ctrl u_pulse_mod_ctrl (.*);
    // reduced variant on the same bus, only its modulation output is watched
    pulse_mod_ctrl #(.ENHANCED(0), .ADDR_W(8)) u_pulse_mod_ctrl_red
    (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(s_axi_awprot),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(),
        .s_axi_bresp(),
        .s_axi_bvalid(),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(s_axi_arprot),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(),
        .s_axi_rdata(),
        .s_axi_rresp(),
        .s_axi_rvalid(),
        .s_axi_rready(s_axi_rready),
        .i_pulse_in(i_pulse_in),
        .o_pulse_mod(red_pulse_mod),
        .o_rf_blank(),
        .o_marker()
    );
    pulse_source u_pulse_source (.i_run(use_src), .o_pulse(src_pulse));

    always #25 i_clk = ~i_clk;

    always @(posedge i_clk)
        if (o_marker)
            mark_cnt <= mark_cnt + 1;

    task end_sim;
        begin
            $display("checks %0d mismatches %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    always @(posedge i_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            fail_count = fail_count + 1;
            $display("mismatch at %0t: timeout", $time);
            end_sim;
        end
    end

    task chk_word(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp)
            begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task chk_bit(input got, input exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    task done(input string name);
        $display("test %0s finished", name);
    endtask

    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do
            begin
                @(posedge i_clk);
                if (s_axi_awready)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wready)
                    s_axi_wvalid <= 1'b0;
            end while (!s_axi_bvalid);
            s_axi_bready <= 1'b0;
            chk_word({30'h0, s_axi_bresp}, {30'h0, er});
            @(posedge i_clk);
        end
    endtask

    task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do
            begin
                @(posedge i_clk);
                if (s_axi_arready)
                    s_axi_arvalid <= 1'b0;
            end while (!s_axi_rvalid);
            s_axi_rready <= 1'b0;
            chk_word(s_axi_rdata, ed);
            chk_word({30'h0, s_axi_rresp}, {30'h0, er});
            @(posedge i_clk);
        end
    endtask

    // level applied on a clock edge must show before the next edge
    task ext_case(input [6:0] c, input lv, input em, input eb);
        begin
            tb_level <= !lv;
            wr(`PMC_CTRL_OFS, {25'h0, c}, `PMC_RESP_OKAY);
            tb_level <= lv;
            @(negedge i_clk);
            chk_bit(o_pulse_mod, em);
            chk_bit(o_rf_blank, eb);
            @(posedge i_clk);
        end
    endtask

    task count(input integer n);
        begin
            hi = 0;
            rises = 0;
            red_rises = 0;
            prev = o_pulse_mod;
            prev_red = red_pulse_mod;
            repeat (n)
            begin
                @(posedge i_clk);
                hi = hi + o_pulse_mod;
                rises = rises + (o_pulse_mod & ~prev);
                red_rises = red_rises + (red_pulse_mod & ~prev_red);
                prev = o_pulse_mod;
                prev_red = red_pulse_mod;
            end
        end
    endtask

    initial
    begin
        repeat (20) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk_bit(o_marker, 1'b1);
        chk_bit(o_pulse_mod | o_rf_blank, 1'b0);
        rd(`PMC_CTRL_OFS, 32'h0, `PMC_RESP_OKAY);
        rd(`PMC_PER_LO_OFS, 32'h7d0, `PMC_RESP_OKAY);
        rd(`PMC_PER_HI_OFS, 32'h0, `PMC_RESP_OKAY);
        rd(`PMC_STAT_OFS, 32'h1, `PMC_RESP_OKAY);
        rd(8'h10, 32'h0, `PMC_RESP_SLVERR);
        wr(8'h10, 32'h1, `PMC_RESP_SLVERR);
        wr(`PMC_PER_HI_OFS, 32'hfffffff4, `PMC_RESP_OKAY);
        rd(`PMC_PER_HI_OFS, 32'h4, `PMC_RESP_OKAY);
        wr(`PMC_PER_HI_OFS, 32'h0, `PMC_RESP_OKAY);
        chk_bit(o_marker, 1'b1);
        repeat (45) @(posedge i_clk);
        chk_bit(o_marker, 1'b0);
        done("registers");
        ext_case(7'h01, 1'b1, 1'b1, 1'b0);
        ext_case(7'h01, 1'b0, 1'b0, 1'b1);
        ext_case(7'h09, 1'b1, 1'b0, 1'b1);
        ext_case(7'h05, 1'b1, 1'b1, 1'b1);
        ext_case(7'h00, 1'b1, 1'b0, 1'b0);
        wr(`PMC_CTRL_OFS, 32'h01, `PMC_RESP_OKAY);
        use_src <= 1'b1;
        for (k = 0; k < 20; k = k + 1)
        begin
            @(src_pulse);
            #1;
            chk_bit(o_pulse_mod, src_pulse);
        end
        @(posedge i_clk);
        use_src <= 1'b0;
        done("external");
        tb_level <= 1'b0;
        wr(`PMC_CTRL_OFS, 32'h11, `PMC_RESP_OKAY);
        tb_level <= 1'b1;
        @(negedge i_clk);
        chk_bit(o_pulse_mod, 1'b0);
        @(posedge i_clk);
        @(negedge i_clk);
        chk_bit(o_pulse_mod, 1'b0);
        @(negedge i_clk);
        chk_bit(o_pulse_mod, 1'b1);
        @(posedge i_clk);
        done("resync");
        wr(`PMC_CTRL_OFS, 32'h00, `PMC_RESP_OKAY);
        wr(`PMC_CTRL_OFS, 32'h29, `PMC_RESP_OKAY);
        chk_bit(o_pulse_mod, 1'b1);
        count(200);
        chk_word(hi, 32'h64);
        chk_word(rises, 32'h1);
        wr(`PMC_PER_LO_OFS, 32'h190, `PMC_RESP_OKAY);
        repeat (210) @(posedge i_clk);
        count(200);
        chk_word(rises, 32'h5);
        chk_word(red_rises, 32'h2);
        wr(`PMC_CTRL_OFS, 32'h41, `PMC_RESP_OKAY);
        count(200);
        chk_bit(hi > 20 && hi < 180, 1'b1);
        done("generators");
        wr(`PMC_CTRL_OFS, 32'h02, `PMC_RESP_OKAY);
        repeat (5) @(posedge i_clk);
        k = mark_cnt;
        wr(`PMC_CTRL_OFS, 32'h03, `PMC_RESP_OKAY);
        repeat (20) @(posedge i_clk);
        chk_word(mark_cnt - k, 32'h1);
        wr(`PMC_CTRL_OFS, 32'h00, `PMC_RESP_OKAY);
        chk_bit(o_marker, 1'b1);
        done("marker");
        end_sim;
    end
endmodule // test_pulse_modulation_control

bind pulse_mod_ctrl pmc_assertions u_pmc_assertions (.*);
